/* File: include/dsr_pkg.sv */
// Constants and types shared by the status, indicator and run-relay block.
package dsr_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses on the Avalon-MM slave)
    // ----------------------------------------------------------------
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] SCALE_OFFSET = 4'h4;
    localparam logic [3:0] STATUS_OFFSET = 4'h8;
    localparam logic [3:0] ANALOG_OFFSET = 4'hc;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int TERM_FUNC_LSB = 0;
    localparam int ANA_RANGE_LSB = 4;
    localparam int INVERT_BIT = 6;
    localparam int STOP_MODE_BIT = 7;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] SCALE_RESET = 32'h0000_0100;
    localparam int STAT_CODE_LSB = 8;
    localparam int STAT_INPUT_LSB = 16;

    // ----------------------------------------------------------------
    // Terminal function codes and analog ranges
    // ----------------------------------------------------------------
    localparam logic [3:0] TF_DEFAULT = 4'h0;
    localparam logic [3:0] TF_REV_PRESET_BITS = 4'h2;
    localparam logic [3:0] TF_UP_PRESET_DOWN = 4'h4;
    localparam logic [3:0] TF_UP_EXTFAULT_DOWN = 4'h5;
    localparam logic [3:0] TF_REV_UP_DOWN = 4'h6;
    localparam logic [3:0] TF_BITS_EXTFAULT = 4'h7;
    localparam logic [1:0] AR_VOLT_10 = 2'h0;
    localparam logic [1:0] AR_MA_0_20 = 2'h1;
    localparam logic [1:0] AR_MA_LZ_FAULT = 2'h2;
    localparam logic [1:0] AR_MA_LZ_PRESET = 2'h3;

    // ----------------------------------------------------------------
    // Fault codes shown on the fault-code LED
    // ----------------------------------------------------------------
    localparam logic [3:0] FC_NONE = 4'h0;
    localparam logic [3:0] FC_EXTERNAL = 4'h2;
    localparam logic [3:0] FC_LIVE_ZERO = 4'ha;

    // ----------------------------------------------------------------
    // Analog scaling
    // ----------------------------------------------------------------
    localparam int ADC_MAX = 4095;
    localparam int FULL_SCALE_UA = 20000;
    localparam int LIVE_ZERO_UA = 3000;
    localparam int OFFSET_UA = 4000;
    localparam logic [11:0] LIVE_ZERO_COUNT = 12'(ADC_MAX * LIVE_ZERO_UA / FULL_SCALE_UA);
    localparam logic [11:0] OFFSET_COUNT = 12'(ADC_MAX * OFFSET_UA / FULL_SCALE_UA);
    localparam int SCALE_FRAC_BITS = 8;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int RUN_FLASH_HZ = 4;
    localparam int FAULT_BLINK_HZ = 2;
    localparam int FAULT_PAUSE_MS = 2000;
    localparam int RUN_HALF_CYCLES = CLK_HZ / (2 * RUN_FLASH_HZ);
    localparam int FAULT_HALF_CYCLES = CLK_HZ / (2 * FAULT_BLINK_HZ);
    localparam logic [5:0] PAUSE_HALVES = 6'(FAULT_PAUSE_MS * 2 * FAULT_BLINK_HZ / 1000);

    typedef enum logic [1:0] {RLY_OPEN, RLY_CLOSED, RLY_RAMP} dsr_relay_state_t;

endpackage

/* File: hw/dsr_tick_gen.sv */
// Free-running half-period divider giving a square wave and a tick per half period.
`timescale 1ns/10ps
module dsr_tick_gen #(
    parameter int HALF_CYCLES = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Outputs
    output logic wave,
    output logic tick
);
    localparam int W = $clog2(HALF_CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(HALF_CYCLES - 1);

    logic [W-1:0] cnt_q;
    logic wave_q;
    logic tick_q;
    wire wrap = (cnt_q == LAST);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            wave_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= wrap ? '0 : cnt_q + 1'b1;
            wave_q <= wave_q ^ wrap;
            tick_q <= wrap;
        end
    end

    assign wave = wave_q;
    assign tick = tick_q;
endmodule

/* File: hw/dsr_fault_pulser.sv */
// Fault-code burst generator: code pulses at the blink rate, then a fixed pause.
`timescale 1ns/10ps
module dsr_fault_pulser (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Timing and code
    input wire logic halfTick,
    input wire logic [3:0] code,
    // Output
    output logic pulse
);
    logic [5:0] cnt_q;
    logic [3:0] code_q;
    logic pulse_q;

    // The code is caught only at the start of a burst so a change never cuts one short.
    wire [5:0] burstLen = {1'b0, code_q, 1'b0};
    wire [5:0] lastCnt = 6'(burstLen + dsr_pkg::PAUSE_HALVES - 6'h01);
    wire atStart = (cnt_q == 6'h00);
    wire pulse_d = (code_q != dsr_pkg::FC_NONE) && (cnt_q < burstLen) && !cnt_q[0];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            code_q <= dsr_pkg::FC_NONE;
            pulse_q <= 1'b0;
        end else begin
            if (atStart) begin
                code_q <= code;
            end
            if (halfTick) begin
                cnt_q <= (code_q == dsr_pkg::FC_NONE || cnt_q == lastCnt) ? 6'h00 : cnt_q + 6'h01;
            end
            pulse_q <= pulse_d;
        end
    end

    assign pulse = pulse_q;

    chk_pause_dark: assert property (@(posedge clk) disable iff (rst)
        (cnt_q >= burstLen) |=> !pulse) else $error("fault LED lit during pause");
endmodule

/* File: hw/dsr_indicator_relay.sv */
// Terminal decode, analog reference, run relay and status LEDs of the starter.
//
// Function
// - Terminal four analog unless function reassigns it.
// - Four analog ranges, live-zero fault or preset.
// - Analog reference scaled and optionally inverted.
// - Function codes map terminals two to four.
// - Relay closes on request without fault.
// - Drive, external, live-zero or comms fault opens relay immediately.
// - Coast stop opens relay at once.
// - Ramp stop holds relay until zero.
// - Run LED flashes when idle and healthy.
// - Run LED steady while running with request.
// - Run LED dark on supply or comms fault.
// - Undervoltage blinks status and fault LEDs.
// - Drive fault lights status LED steady.
// - Fault code pulses, then pause, repeating.
// - Pulse count equals the fault code number.
// - Comms fault lights both red LEDs steady.
// - DC braking lights fault LED yellow.
// - Default terminals: forward, reverse, preset one.
//
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
module dsr_indicator_relay #(
    parameter int RUN_HALF_CYCLES = dsr_pkg::RUN_HALF_CYCLES,
    parameter int FAULT_HALF_CYCLES = dsr_pkg::FAULT_HALF_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [3:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    input wire logic [3:0] avsByteenable,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    // Input terminals
    input wire logic inputTerminalOne,
    input wire logic inputTerminalTwo,
    input wire logic inputTerminalThree,
    input wire logic inputTerminalFourDigital,
    input wire logic [11:0] analogReferenceInput,
    // Drive state
    input wire logic runPermit,
    input wire logic [3:0] driveFaultCode,
    input wire logic commFault,
    input wire logic internalPowerSupplyOk,
    input wire logic mainsUndervoltage,
    input wire logic dcBrakeActive,
    input wire logic rampAtZero,
    // Decoded terminal functions
    output logic forwardRunRequest,
    output logic reverseRunRequest,
    output logic presetSpeedOne,
    output logic [1:0] presetSpeedSelectBits,
    output logic speedUp,
    output logic speedDown,
    output logic externalFaultInput,
    output logic liveZeroFault,
    output logic [11:0] analogReference,
    // Relay and LEDs
    output logic runRelay,
    output logic runLedGreen,
    output logic statusLedRed,
    output logic faultLedRed,
    output logic faultLedYellow
);
    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic [31:0] beMerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [11:0] sat12(input logic [27:0] v);
        return (v > 28'(dsr_pkg::ADC_MAX)) ? 12'(dsr_pkg::ADC_MAX) : v[11:0];
    endfunction

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] scale_q;
    logic [31:0] readdata_q;
    logic ack_q;

    // One wait state: read data is prepared on the first edge and taken on the second.
    wire busReq = avsRead || avsWrite;
    wire busDone = busReq && ack_q;
    wire [31:0] scaleMerged = beMerge(scale_q, avsWritedata, avsByteenable);
    wire hitCtrl = (avsAddress == dsr_pkg::CTRL_OFFSET);
    wire hitScale = (avsAddress == dsr_pkg::SCALE_OFFSET);
    wire hitStatus = (avsAddress == dsr_pkg::STATUS_OFFSET);
    wire hitAnalog = (avsAddress == dsr_pkg::ANALOG_OFFSET);

    wire [3:0] termFunc = ctrl_q[dsr_pkg::TERM_FUNC_LSB +: 4];
    wire [1:0] anaRange = ctrl_q[dsr_pkg::ANA_RANGE_LSB +: 2];
    wire invertRef = ctrl_q[dsr_pkg::INVERT_BIT];
    wire rampStop = ctrl_q[dsr_pkg::STOP_MODE_BIT];

    // ----------------------------------------------------------------
    // Terminal decode
    // ----------------------------------------------------------------
    wire t2 = inputTerminalTwo;
    wire t3 = inputTerminalThree;
    wire t4 = inputTerminalFourDigital;
    wire fcDefault = (termFunc == dsr_pkg::TF_DEFAULT);
    wire fcRevBits = (termFunc == dsr_pkg::TF_REV_PRESET_BITS);
    wire fcUpPreset = (termFunc == dsr_pkg::TF_UP_PRESET_DOWN);
    wire fcUpExt = (termFunc == dsr_pkg::TF_UP_EXTFAULT_DOWN);
    wire fcRevUp = (termFunc == dsr_pkg::TF_REV_UP_DOWN);
    wire fcBitsExt = (termFunc == dsr_pkg::TF_BITS_EXTFAULT);
    // Codes without a digital use of terminal four keep it as the analog input.
    wire termFourDigital = fcRevBits || fcUpPreset || fcUpExt || fcRevUp || fcBitsExt;

    wire [11:0] raw = analogReferenceInput;
    wire currentOffset = anaRange[1];
    wire belowLiveZero = currentOffset && !termFourDigital && (raw < dsr_pkg::LIVE_ZERO_COUNT);
    wire liveZeroNow = belowLiveZero && (anaRange == dsr_pkg::AR_MA_LZ_FAULT);
    wire liveZeroPreset = belowLiveZero && (anaRange == dsr_pkg::AR_MA_LZ_PRESET);

    wire fwdNow = inputTerminalOne;
    wire revNow = ((fcDefault || fcRevBits || fcRevUp) && t2) || (!termFourDigital && !fcDefault && t2);
    wire presetOneNow = ((!termFourDigital && t3) || (fcUpPreset && t3)) || liveZeroPreset;
    wire [1:0] presetBitsNow = fcRevBits ? {t4, t3} : (fcBitsExt ? {t4, t2} : 2'b00);
    wire upNow = ((fcUpPreset || fcUpExt) && t2) || (fcRevUp && t3);
    wire downNow = (fcUpPreset || fcUpExt || fcRevUp) && t4;
    wire extFaultNow = (fcUpExt || fcBitsExt) && t3;

    // ----------------------------------------------------------------
    // Analog reference
    // ----------------------------------------------------------------
    // The 4-20 mA span is stretched by 5/4 so that 20 mA still reaches full scale.
    wire [11:0] offRaw = (raw > dsr_pkg::OFFSET_COUNT) ? 12'(raw - dsr_pkg::OFFSET_COUNT) : 12'h000;
    wire [11:0] spanRaw = currentOffset ? sat12(28'(offRaw) + 28'(offRaw >> 2)) : raw;
    wire [11:0] scaledRef = sat12(28'((spanRaw * scale_q[15:0]) >> dsr_pkg::SCALE_FRAC_BITS));
    wire [11:0] finalRef = invertRef ? 12'(12'(dsr_pkg::ADC_MAX) - scaledRef) : scaledRef;

    // ----------------------------------------------------------------
    // Run relay
    // ----------------------------------------------------------------
    dsr_pkg::dsr_relay_state_t state_q;
    dsr_pkg::dsr_relay_state_t state_d;

    wire runReq = fwdNow || revNow || runPermit;
    wire anyFault = (driveFaultCode != dsr_pkg::FC_NONE) || extFaultNow || liveZeroNow || commFault;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            dsr_pkg::RLY_OPEN: begin
                if (runReq && !anyFault) begin
                    state_d = dsr_pkg::RLY_CLOSED;
                end
            end
            dsr_pkg::RLY_CLOSED: begin
                if (anyFault) begin
                    state_d = dsr_pkg::RLY_OPEN;
                end else if (!runReq) begin
                    state_d = rampStop ? dsr_pkg::RLY_RAMP : dsr_pkg::RLY_OPEN;
                end
            end
            dsr_pkg::RLY_RAMP: begin
                // Switching to coasting during a ramp must open the contact at once as well.
                if (anyFault || (!runReq && (rampAtZero || !rampStop))) begin
                    state_d = dsr_pkg::RLY_OPEN;
                end else if (runReq) begin
                    state_d = dsr_pkg::RLY_CLOSED;
                end
            end
            default: begin
                state_d = dsr_pkg::RLY_OPEN;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Indicators
    // ----------------------------------------------------------------
    logic runWave;
    logic blinkWave;
    logic blinkTick;
    logic codePulse;

    dsr_tick_gen #(.HALF_CYCLES(RUN_HALF_CYCLES)) u_run_tick (
        .clk(clk),
        .rst(rst),
        .wave(runWave),
        .tick()
    );

    dsr_tick_gen #(.HALF_CYCLES(FAULT_HALF_CYCLES)) u_blink_tick (
        .clk(clk),
        .rst(rst),
        .wave(blinkWave),
        .tick(blinkTick)
    );

    // A drive code wins; terminal faults fall back to their own codes.
    wire [3:0] shownCode = (driveFaultCode != dsr_pkg::FC_NONE) ? driveFaultCode :
                           extFaultNow ? dsr_pkg::FC_EXTERNAL :
                           liveZeroNow ? dsr_pkg::FC_LIVE_ZERO : dsr_pkg::FC_NONE;

    dsr_fault_pulser u_pulser (
        .clk(clk),
        .rst(rst),
        .halfTick(blinkTick),
        .code(shownCode),
        .pulse(codePulse)
    );

    wire relayClosed = (state_q != dsr_pkg::RLY_OPEN);
    wire runDark = !internalPowerSupplyOk || commFault || mainsUndervoltage;
    wire runSteady = relayClosed && runReq;
    wire runIdle = !fwdNow && !revNow && !anyFault;
    wire runLed_d = !runDark && (runSteady || (runIdle && runWave));
    wire statusLed_d = mainsUndervoltage ? blinkWave : anyFault;
    wire faultRed_d = mainsUndervoltage ? blinkWave : (commFault || (anyFault && codePulse));
    wire faultYellow_d = dcBrakeActive && !mainsUndervoltage && !anyFault;

    wire [31:0] statusWord = {8'h00, 4'h0, speedDown, speedUp, reverseRunRequest, forwardRunRequest,
                              4'h0, shownCode, 1'b0, termFourDigital, liveZeroFault, faultLedYellow,
                              faultLedRed, statusLedRed, runLedGreen, runRelay};
    wire [31:0] readMux = hitCtrl ? ctrl_q : hitScale ? scale_q : hitStatus ? statusWord :
                          hitAnalog ? {20'h00000, analogReference} : 32'h0000_0000;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
            readdata_q <= '0;
            ctrl_q <= dsr_pkg::CTRL_RESET;
            scale_q <= dsr_pkg::SCALE_RESET;
        end else begin
            ack_q <= busReq && !ack_q;
            if (busReq && !ack_q) begin
                readdata_q <= avsRead ? readMux : 32'h0000_0000;
            end
            if (busDone && avsWrite && hitCtrl) begin
                ctrl_q <= beMerge(ctrl_q, avsWritedata, avsByteenable);
            end
            if (busDone && avsWrite && hitScale) begin
                scale_q <= {16'h0000, scaleMerged[15:0]};
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= dsr_pkg::RLY_OPEN;
            forwardRunRequest <= 1'b0;
            reverseRunRequest <= 1'b0;
            presetSpeedOne <= 1'b0;
            presetSpeedSelectBits <= 2'b00;
            speedUp <= 1'b0;
            speedDown <= 1'b0;
            externalFaultInput <= 1'b0;
            liveZeroFault <= 1'b0;
            analogReference <= 12'h000;
            runLedGreen <= 1'b0;
            statusLedRed <= 1'b0;
            faultLedRed <= 1'b0;
            faultLedYellow <= 1'b0;
        end else begin
            state_q <= state_d;
            forwardRunRequest <= fwdNow;
            reverseRunRequest <= revNow;
            presetSpeedOne <= presetOneNow;
            presetSpeedSelectBits <= presetBitsNow;
            speedUp <= upNow;
            speedDown <= downNow;
            externalFaultInput <= extFaultNow;
            liveZeroFault <= liveZeroNow;
            analogReference <= termFourDigital ? 12'h000 : finalRef;
            runLedGreen <= runLed_d;
            statusLedRed <= statusLed_d;
            faultLedRed <= faultRed_d;
            faultLedYellow <= faultYellow_d;
        end
    end

    assign runRelay = relayClosed;
    assign avsWaitrequest = busReq && !ack_q;
    assign avsReaddata = readdata_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_fault_opens_relay: assert property (anyFault |=> !runRelay)
        else $error("relay stayed closed with a fault");
    chk_relay_close_cause: assert property ($rose(runRelay) |-> $past(runReq) && !$past(anyFault))
        else $error("relay closed without request or with fault");
    chk_coast_stop_open: assert property (runRelay && !runReq && !rampStop |=> !runRelay)
        else $error("relay not opened on coast stop");
    chk_ramp_stop_hold: assert property (runRelay && !runReq && rampStop && !rampAtZero && !anyFault
        |=> runRelay)
        else $error("relay opened before ramp reached zero");
    chk_run_led_dark: assert property ((!internalPowerSupplyOk || commFault) |=> !runLedGreen)
        else $error("run LED lit without supply");
    chk_run_led_steady: assert property ((runRelay && runReq && !runDark)[*2] |-> runLedGreen)
        else $error("run LED not steady while running");
    chk_idle_flash_rate: assert property ($rose(runWave) |-> ##1 ($stable(runWave))[*3])
        else $error("run flash divider too fast");
    chk_uv_together: assert property ($past(mainsUndervoltage) |-> statusLedRed == faultLedRed
        && !runLedGreen)
        else $error("undervoltage LEDs not together");
    chk_fault_status_red: assert property (anyFault && !mainsUndervoltage |=> statusLedRed)
        else $error("status LED dark during fault");
    chk_comm_both_red: assert property (commFault && !mainsUndervoltage |=> faultLedRed && statusLedRed)
        else $error("comms fault LEDs not steady red");
    chk_brake_yellow: assert property (dcBrakeActive && !mainsUndervoltage && !anyFault
        |=> faultLedYellow && !faultLedRed)
        else $error("braking not shown yellow");
    chk_default_decode: assert property (fcDefault && !liveZeroPreset |=> forwardRunRequest == $past(inputTerminalOne)
        && reverseRunRequest == $past(inputTerminalTwo) && presetSpeedOne == $past(inputTerminalThree))
        else $error("default terminal decode wrong");
    chk_mode5_decode: assert property (fcUpExt |=> speedUp == $past(t2) && externalFaultInput == $past(t3)
        && speedDown == $past(t4))
        else $error("terminal function five decode wrong");
    chk_live_zero_flag: assert property (anaRange == dsr_pkg::AR_MA_LZ_FAULT && !termFourDigital
        && raw < dsr_pkg::LIVE_ZERO_COUNT |=> liveZeroFault)
        else $error("live zero not flagged");
    chk_bus_one_wait: assert property (busReq && avsWaitrequest |=> !avsWaitrequest)
        else $error("bus answer later than one wait state");

    cov_ramp_stop: cover property (state_q == dsr_pkg::RLY_RAMP ##1 state_q == dsr_pkg::RLY_OPEN);
    cov_uv_blink: cover property (mainsUndervoltage && $rose(statusLedRed));
    cov_fault_pulse: cover property (anyFault && $rose(faultLedRed));
endmodule

/* File: tb/dsr_drive_model.sv */
// Far-side model: terminal levels, drive state and a motor that needs time to ramp down.
`timescale 1ns/10ps
module dsr_drive_model #(
    parameter int DECEL = 10
) (
    // Clock, reset and command
    input wire logic clk,
    input wire logic rst,
    input wire logic [24:0] cmd,
    // Terminals and drive state
    output logic [24:0] pins,
    output logic rampAtZero
);
    // ----------------------------------------------------------------
    // Deceleration
    // ----------------------------------------------------------------
    // Zero speed comes a fixed time after the last request, so a ramp stop is visibly delayed.
    int idleCnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pins <= 25'h0;
            idleCnt <= 0;
        end else begin
            pins <= cmd;
            idleCnt <= (cmd[0] | cmd[1] | cmd[12]) ? 0 : ((idleCnt < DECEL) ? idleCnt + 1 : idleCnt);
        end
    end
    assign rampAtZero = (idleCnt >= DECEL);
endmodule

/* File: tb/dsr_indicator_relay_tb_top.sv */
// Self-checking bench for the indicator and run-relay block.
`timescale 1ns/10ps
module dsr_indicator_relay_tb_top;
    // ----------------------------------------------------------------
    // Harness
    // ----------------------------------------------------------------
    logic clk = 0, rst = 1, avsRead = 0, avsWrite = 0, avsWaitrequest, rampAtZero;
    logic [3:0] avsAddress = 4'h0, avsByteenable = 4'hf;
    logic [31:0] avsWritedata = 32'h0, avsReaddata, q;
    logic [24:0] cmd = 25'h0, p;
    logic forward_run_request, ext, pre, relay, runLed, stRed, fRed, fYel;
    logic [1:0] pBits;
    logic [11:0] anaRef;
    int miscompares = 0, cmp_count = 0, n;
    initial forever #12.5 clk = ~clk;
    dsr_drive_model #(.DECEL(10)) pm (.clk(clk), .rst(rst), .cmd(cmd), .pins(p), .rampAtZero(rampAtZero));
    dsr_indicator_relay #(.RUN_HALF_CYCLES(4), .FAULT_HALF_CYCLES(6)) dut (.clk(clk), .rst(rst),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
        .avsByteenable(avsByteenable), .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
        .inputTerminalOne(p[0]), .inputTerminalTwo(p[1]), .inputTerminalThree(p[2]),
        .inputTerminalFourDigital(p[3]), .analogReferenceInput(p[24:13]), .runPermit(p[12]),
        .driveFaultCode(p[7:4]), .commFault(p[8]), .internalPowerSupplyOk(p[9]), .mainsUndervoltage(p[10]),
        .dcBrakeActive(p[11]), .rampAtZero(rampAtZero), .forwardRunRequest(forward_run_request), .reverseRunRequest(),
        .presetSpeedOne(pre), .presetSpeedSelectBits(pBits), .speedUp(), .speedDown(), .externalFaultInput(ext),
        .liveZeroFault(), .analogReference(anaRef), .runRelay(relay), .runLedGreen(runLed),
        .statusLedRed(stRed), .faultLedRed(fRed), .faultLedYellow(fYel));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic summarize();
        if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avsAddress <= a;
        avsWritedata <= d;
        avsWrite <= wr;
        avsRead <= !wr;
        do @(posedge clk); while (avsWaitrequest !== 1'b0);
        q = avsReaddata;
        avsRead <= 0;
        avsWrite <= 0;
        @(posedge clk);
    endtask
    task automatic setc(input logic [24:0] v, input int w);
        cmd <= v;
        repeat (w) @(posedge clk);
    endtask
    // Counts rising edges of status (0), fault red (1) or run (2) LED; when counting status (0), status must track fault red.
    task automatic rises(input int s, input int cyc);
        logic l, c;
        n = 0;
        l = 0;
        repeat (cyc) begin
            @(posedge clk);
            c = (s == 0) ? stRed : ((s == 1) ? fRed : runLed);
            if (c === 1'b1 && l !== 1'b1) n++;
            l = c;
            if (s == 0) chk(stRed, fRed);
        end
    endtask
    task automatic t_regs();
        bus(0, dsr_pkg::CTRL_OFFSET, 0); chk(q, dsr_pkg::CTRL_RESET);
        bus(0, dsr_pkg::SCALE_OFFSET, 0); chk(q, dsr_pkg::SCALE_RESET);
        bus(1, 4'h2, 32'hffff_ffff); bus(0, 4'h2, 0); chk(q, 0);
    endtask
    task automatic t_run();
        setc(25'h201, 4); chk({forward_run_request, relay, runLed}, 3'h7);
        setc(25'h231, 3); chk({relay, stRed}, 2'h1);
        setc(25'h231, 84); rises(1, 168); chk(n, 6);
        setc(25'h301, 3); chk({relay, runLed, stRed, fRed}, 4'h3);
        setc(25'ha00, 3); chk(fYel, 1);
        setc(25'h600, 3); rises(0, 24); chk(n, 2);
        setc(25'h200, 3); rises(2, 16); chk(n, 2);
    endtask
    task automatic t_stop();
        setc(25'h201, 3); setc(25'h200, 3); chk(relay, 0);
        bus(1, dsr_pkg::CTRL_OFFSET, 32'h80);
        setc(25'h201, 3); setc(25'h200, 3); chk(relay, 1);
        repeat (12) @(posedge clk); chk(relay, 0);
        bus(1, dsr_pkg::CTRL_OFFSET, 32'h5);
        setc(25'h205, 3); chk({ext, relay}, 2'h2);
        bus(1, dsr_pkg::CTRL_OFFSET, 32'h0);
        setc({12'h123, 13'h200}, 3); chk(anaRef, 12'h123);
        bus(1, dsr_pkg::CTRL_OFFSET, 32'h40);
        repeat (3) @(posedge clk); chk(anaRef, 12'hedc);
    endtask
    task automatic t_modes();
        bus(1, dsr_pkg::CTRL_OFFSET, 32'h2);
        setc(25'h20e, 3); chk({forward_run_request, pre, pBits}, 4'h3);
        bus(0, dsr_pkg::STATUS_OFFSET, 0); chk(q[19:16], 4'h2);
        bus(1, dsr_pkg::CTRL_OFFSET, 32'h20);
        setc({12'h100, 13'h201}, 3); chk({relay, stRed}, 2'h1);
        bus(0, dsr_pkg::STATUS_OFFSET, 0); chk({q[11:8], q[5]}, 5'h15);
        setc({12'h800, 13'h200}, 3); chk(anaRef, 12'h600);
        bus(1, dsr_pkg::SCALE_OFFSET, 32'h180);
        repeat (3) @(posedge clk); chk(anaRef, 12'h900);
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        t_regs();
        t_run();
        t_stop();
        t_modes();
        summarize();
    end
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        summarize();
    end
endmodule
